// ==== src/adcdc_pkg.sv ====
// Summary of operation
// RULE_01: converter clock is system clock divided 2,2,4,8,16,32,64,128 by select code
// RULE_02: each finished conversion result is placed into the two result bytes
// RULE_03: reading the low byte blocks result updates until the high byte is read
// RULE_04: software reads low byte first, or only high byte for 8-bit left-adjusted
// RULE_05: right adjust puts bits 9:8 high, 7:0 low; left adjust 9:2 high, 1:0 low
// RULE_06: left-adjust changes result presentation at once, even mid-conversion
// RULE_07: polarity bit 7 of second control defaults unipolar, one selects bipolar
// RULE_08: unipolar gives 10-bit result, saturated when negative input is larger
// RULE_09: bipolar gives two's complement result, 9 magnitude bits plus sign
// RULE_10: software always writes zero to reserved bit 5 of second control
// RULE_11: bit 3 of second control is plain storage reading back last write
// RULE_12: trigger source select is ignored while auto-trigger is disabled
// RULE_13: with auto-trigger on, rising edge of selected flag starts conversion
// RULE_14: reselecting from a clear flag to a set flag gives a rising trigger edge
// RULE_15: selecting free-running code zero never makes a trigger event itself
// RULE_16: trigger codes: free, comparator, ext int 0, t0 A, t0 ovf, t1 B, t1 ovf, cap
// RULE_17: each set input-disable bit turns off the pin buffer, pin reads zero
// RULE_18: conversion takes 13 converter clocks, the first after enable takes 25
// RULE_19: complete flag sets at finish, clears on vector acknowledge or writing one
// RULE_20: writing one to auto-trigger enable allows starts from trigger edges
// RULE_21: prescaler is held reset while the converter is disabled
// RULE_22: result and input-disable registers clear to zero on reset
package adcdc_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [5:0] OFS_PIN_DIS = 6'h01;
  localparam logic [5:0] OFS_CTRL2   = 6'h03;
  localparam logic [5:0] OFS_RES_LO  = 6'h04;
  localparam logic [5:0] OFS_RES_HI  = 6'h05;
  localparam logic [5:0] OFS_CTRL1   = 6'h06;

  // --------------------------------------------------------------
  // register layouts and reset values
  // --------------------------------------------------------------
  typedef struct packed {
    logic       converter_enable;
    logic       conversion_start;
    logic       auto_trigger_enable;
    logic       conversion_complete_flag;
    logic       int_enable;
    logic [2:0] clock_divider_select;
  } adcdc_ctrl1_s;

  typedef struct packed {
    logic       bipolar_select;
    logic       comparator_mux_enable;
    logic       reserved_zero;
    logic       left_adjust_result;
    logic       spare_bit;
    logic [2:0] trigger_source_select;
  } adcdc_ctrl2_s;

  localparam adcdc_ctrl1_s CTRL1_RST   = 8'h00;
  localparam adcdc_ctrl2_s CTRL2_RST   = 8'h00;
  localparam logic [7:0]   PIN_DIS_RST = 8'h00;
  localparam logic [9:0]   RES_RST     = 10'h000;
  localparam logic [9:0]   RES_SAT     = 10'h3ff;
  localparam logic [7:0]   RD_UNMAPPED = 8'h00;
  localparam logic [5:0]   LO_PAD      = 6'h00;

  // --------------------------------------------------------------
  // timing and trigger codes
  // --------------------------------------------------------------
  localparam logic [4:0] CYC_FIRST  = 5'h19;
  localparam logic [4:0] CYC_NORMAL = 5'h0d;
  localparam logic [2:0] DIV_SEL_8  = 3'h3;

  typedef enum logic [2:0] {
    TRIG_FREE    = 3'h0,
    TRIG_CMP     = 3'h1,
    TRIG_EXT0    = 3'h2,
    TRIG_T0_CMPA = 3'h3,
    TRIG_T0_OVF  = 3'h4,
    TRIG_T1_CMPB = 3'h5,
    TRIG_T1_OVF  = 3'h6,
    TRIG_T1_CAP  = 3'h7
  } adcdc_trig_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_DONE = 2'h3
  } adcdc_state_e;

  // low bits of the prescaler that must be all ones for a tick
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = 7'h01;
    case (sel)
      3'h2:    m = 7'h03;
      3'h3:    m = 7'h07;
      3'h4:    m = 7'h0f;
      3'h5:    m = 7'h1f;
      3'h6:    m = 7'h3f;
      3'h7:    m = 7'h7f;
      default: m = 7'h01;
    endcase
    return m;
  endfunction

endpackage

// ==== src/adcdc_top.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ps
module adcdc_top (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  input  wire logic [9:0] core_mag,
  input  wire logic       core_neg,
  output logic            conv_clk_q,
  output logic            sample_hold_q,
  input  wire logic [7:1] trig_flags,
  input  wire logic       vect_ack,
  input  wire logic [7:0] pin_raw,
  output logic      [7:0] pin_in_q,
  output logic      [7:0] pin_buf_off_q
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  adcdc_pkg::adcdc_ctrl1_s ctrl1_q;
  adcdc_pkg::adcdc_ctrl2_s ctrl2_q;
  adcdc_pkg::adcdc_state_e state_q;
  adcdc_pkg::adcdc_state_e state_d;
  logic [9:0]              res_q;
  logic                    lock_q;
  logic                    flag_q;
  logic                    first_q;
  logic                    long_q;
  logic [4:0]              cnt_q;
  logic [6:0]              presc_q;
  logic                    trig_prev_q;
  logic [7:0]              pin_s1_q;
  logic [7:0]              pin_s2_q;
  logic [10:0]             core_s1_q;
  logic [10:0]             core_s2_q;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  adcdc_pkg::adcdc_ctrl1_s wr_c1;
  wire logic wr_ctrl1 = reg_wr && (reg_addr == adcdc_pkg::OFS_CTRL1);
  wire logic wr_ctrl2 = reg_wr && (reg_addr == adcdc_pkg::OFS_CTRL2);
  wire logic wr_pdis  = reg_wr && (reg_addr == adcdc_pkg::OFS_PIN_DIS);
  wire logic rd_lo    = reg_rd && (reg_addr == adcdc_pkg::OFS_RES_LO);
  wire logic rd_hi    = reg_rd && (reg_addr == adcdc_pkg::OFS_RES_HI);
  assign wr_c1 = reg_wdata;

  // enable as it stands after this cycle's write
  wire logic en_d = wr_ctrl1 ? wr_c1.converter_enable
                             : ctrl1_q.converter_enable;
  wire logic en   = ctrl1_q.converter_enable;
  wire logic ate  = ctrl1_q.auto_trigger_enable;

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  wire logic [6:0] mask = adcdc_pkg::div_mask(ctrl1_q.clock_divider_select);
  wire logic conv_tick  = en && ((presc_q & mask) == mask); // [RULE_01]

  // counter held at zero while disabled
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !en)
      presc_q <= 7'h00;                                     // [RULE_21]
    else
      presc_q <= presc_q + 7'h01;
  end

  // --------------------------------------------------------------
  // trigger selection and edge
  // --------------------------------------------------------------
  wire logic [2:0] tsel = ctrl2_q.trigger_source_select;
  // code zero feeds a constant low, so selecting it never makes an edge
  wire logic trig_sig = (tsel == adcdc_pkg::TRIG_FREE) ? 1'b0
                                                       : trig_flags[tsel]; // [RULE_16]
  wire logic trig_edge  = trig_sig && !trig_prev_q;  // [RULE_14] [RULE_15]
  wire logic auto_start = ate && trig_edge;          // [RULE_12] [RULE_13] [RULE_20]
  wire logic done       = (state_q == adcdc_pkg::ST_DONE);
  wire logic free_again = ate && done && (tsel == adcdc_pkg::TRIG_FREE);
  wire logic sw_start   = wr_ctrl1 && wr_c1.conversion_start;
  wire logic start_req  = en_d && (sw_start || auto_start || free_again);
  wire logic [4:0] len  = long_q ? adcdc_pkg::CYC_FIRST
                                 : adcdc_pkg::CYC_NORMAL;

  // edge detector history
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= trig_sig;
  end

  // --------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      adcdc_pkg::ST_IDLE:
        if (start_req)
          state_d = adcdc_pkg::ST_RUN;
      adcdc_pkg::ST_RUN:
        if (conv_tick && (cnt_q == len - 5'h01))
          state_d = adcdc_pkg::ST_DONE;
      adcdc_pkg::ST_DONE:
        state_d = start_req ? adcdc_pkg::ST_RUN : adcdc_pkg::ST_IDLE;
      default:
        state_d = adcdc_pkg::ST_IDLE;
    endcase
    if (!en_d)
      state_d = adcdc_pkg::ST_IDLE;
  end

  // state, cycle count and first-conversion marker
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q <= adcdc_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
      long_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (!en)
        first_q <= 1'b1;
      if (state_d == adcdc_pkg::ST_RUN && state_q != adcdc_pkg::ST_RUN)
      begin
        cnt_q   <= 5'h00;
        long_q  <= first_q;                                 // [RULE_18]
        first_q <= 1'b0;
      end
      else if (conv_tick)
        cnt_q <= cnt_q + 5'h01;
    end
  end

  // --------------------------------------------------------------
  // result formatting and capture
  // --------------------------------------------------------------
  wire logic [9:0] bip_mag = {1'b0, core_s2_q[9:1]};
  wire logic [9:0] res_bip = core_s2_q[10] ? (10'h000 - bip_mag)
                                           : bip_mag;       // [RULE_09]
  wire logic [9:0] res_uni = core_s2_q[10] ? adcdc_pkg::RES_SAT
                                           : core_s2_q[9:0]; // [RULE_08]
  wire logic [9:0] res_new = ctrl2_q.bipolar_select ? res_bip : res_uni;

  // analog result passes two flops before use
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      core_s1_q <= 11'h000;
      core_s2_q <= 11'h000;
    end
    else
    begin
      core_s1_q <= {core_neg, core_mag};
      core_s2_q <= core_s1_q;
    end
  end

  // result store, read lock and complete flag
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      res_q  <= adcdc_pkg::RES_RST;                         // [RULE_22]
      lock_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      if (done && !lock_q)
        res_q <= res_new;                                   // [RULE_02] [RULE_03]
      if (rd_lo)
        lock_q <= 1'b1;                                     // [RULE_03]
      else if (rd_hi)
        lock_q <= 1'b0;
      // set wins over a clear in the same cycle
      if (done)
        flag_q <= 1'b1;                                     // [RULE_19]
      else if (vect_ack ||
               (wr_ctrl1 && wr_c1.conversion_complete_flag))
        flag_q <= 1'b0;                                     // [RULE_19]
    end
  end

  // --------------------------------------------------------------
  // control registers and pin buffers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ctrl1_q       <= adcdc_pkg::CTRL1_RST;
      ctrl2_q       <= adcdc_pkg::CTRL2_RST;                // [RULE_07]
      pin_buf_off_q <= adcdc_pkg::PIN_DIS_RST;              // [RULE_22]
    end
    else
    begin
      if (wr_ctrl1)
      begin
        ctrl1_q                          <= wr_c1;
        ctrl1_q.conversion_start         <= 1'b0;
        ctrl1_q.conversion_complete_flag <= 1'b0;
      end
      if (wr_ctrl2)
      begin
        ctrl2_q               <= reg_wdata;                 // [RULE_11]
        ctrl2_q.reserved_zero <= 1'b0;
      end
      if (wr_pdis)
        pin_buf_off_q <= reg_wdata;
    end
  end

  // pin inputs: two-flop sync, then masked by the disable bits
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_in_q <= 8'h00;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_in_q <= pin_s2_q & ~pin_buf_off_q;                // [RULE_17]
    end
  end

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  wire logic       ladj  = ctrl2_q.left_adjust_result;
  wire logic [7:0] rd_lo_v = ladj ? {res_q[1:0], adcdc_pkg::LO_PAD}
                                  : res_q[7:0];             // [RULE_05] [RULE_06]
  wire logic [7:0] rd_hi_v = ladj ? res_q[9:2]
                                  : {adcdc_pkg::LO_PAD, res_q[9:8]}; // [RULE_05]
  wire logic       busy  = (state_q == adcdc_pkg::ST_RUN);
  wire logic [7:0] rd_c1 = {en, busy, ate, flag_q, ctrl1_q.int_enable,
                            ctrl1_q.clock_divider_select};
  wire logic [7:0] rd_mux =
    (reg_addr == adcdc_pkg::OFS_RES_LO)  ? rd_lo_v :
    (reg_addr == adcdc_pkg::OFS_RES_HI)  ? rd_hi_v :
    (reg_addr == adcdc_pkg::OFS_CTRL1)   ? rd_c1 :
    (reg_addr == adcdc_pkg::OFS_CTRL2)   ? ctrl2_q :
    (reg_addr == adcdc_pkg::OFS_PIN_DIS) ? pin_buf_off_q :
                                           adcdc_pkg::RD_UNMAPPED;

  // read data, converter clock and hold outputs
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata_q   <= adcdc_pkg::RD_UNMAPPED;
      conv_clk_q    <= 1'b0;
      sample_hold_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q   <= reg_rd ? rd_mux : adcdc_pkg::RD_UNMAPPED;
      conv_clk_q    <= conv_tick;
      sample_hold_q <= (state_d == adcdc_pkg::ST_RUN);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  logic [4:0] chk_ticks_q;
  // converter clocks seen in the current conversion
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || state_q != adcdc_pkg::ST_RUN)
      chk_ticks_q <= 5'h00;
    else if (conv_tick)
      chk_ticks_q <= chk_ticks_q + 5'h01;
  end

  sequence s_div8_hold;
    (en && ctrl1_q.clock_divider_select == adcdc_pkg::DIV_SEL_8)[*8];
  endsequence
  sequence s_lo_then_hold;
    rd_lo ##1 !rd_hi;
  endsequence

  div_period_a: assert property ( // [RULE_01]
    conv_tick && ctrl1_q.clock_divider_select == adcdc_pkg::DIV_SEL_8
    ##1 s_div8_hold |-> conv_tick)
    else $error("converter clock period wrong at divide by 8");
  conv_len_a: assert property ( // [RULE_18]
    done |-> chk_ticks_q ==
             (long_q ? adcdc_pkg::CYC_FIRST : adcdc_pkg::CYC_NORMAL))
    else $error("conversion length wrong");
  lock_hold_a: assert property ( // [RULE_03]
    s_lo_then_hold |=> $stable(res_q))
    else $error("result changed while locked");
  left_adj_a: assert property ( // [RULE_05]
    rd_hi && ladj |=> reg_rdata_q == $past(res_q[9:2]))
    else $error("left adjusted high byte wrong");
  uni_sat_a: assert property ( // [RULE_08]
    done && !lock_q && !ctrl2_q.bipolar_select && core_s2_q[10]
    |=> res_q == adcdc_pkg::RES_SAT)
    else $error("unipolar result not saturated");
  flag_set_a: assert property ( // [RULE_19]
    done |=> flag_q && !busy || state_q == adcdc_pkg::ST_RUN)
    else $error("complete flag not set at finish");
  free_edge_a: assert property ( // [RULE_15]
    tsel == adcdc_pkg::TRIG_FREE |-> !trig_edge)
    else $error("free running selection made a trigger");
  no_auto_a: assert property ( // [RULE_12]
    !ate && state_q == adcdc_pkg::ST_IDLE && !sw_start
    |=> state_q == adcdc_pkg::ST_IDLE)
    else $error("conversion started without a start source");
  pin_mask_a: assert property ( // [RULE_17]
    1'b1 |=> (pin_in_q & $past(pin_buf_off_q)) == 8'h00)
    else $error("disabled pin reads non-zero");
  rsvd_zero_a: assert property ( // [RULE_11]
    reg_rd && reg_addr == adcdc_pkg::OFS_CTRL2
    |=> reg_rdata_q[3] == ctrl2_q.spare_bit && !reg_rdata_q[5])
    else $error("second control readback wrong");

endmodule

// ==== verif/adc_digital_control_bench.sv ====
`timescale 1ns/1ps
module adc_digital_control_bench;
  logic       core_clk;
  logic       reset_n;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata_q;
  logic [9:0] core_mag;
  logic       core_neg;
  logic       conv_clk_q;
  logic       sample_hold_q;
  logic [7:1] trig_flags;
  logic       vect_ack;
  logic [7:0] pin_raw;
  logic [7:0] pin_in_q;
  logic [7:0] pin_buf_off_q;
  logic [9:0] want_mag;
  logic       want_neg;
  logic [7:1] want_flags;
  logic [7:0] want_pins;
  logic [5:0] amap [6];
  int         fails;
  int         samples_checked;
  int         cycles;
  int         ticks;
  int         per;
  bit         started;

  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  adcdc_top u_dut (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata_q   (reg_rdata_q),
    .core_mag      (core_mag),
    .core_neg      (core_neg),
    .conv_clk_q    (conv_clk_q),
    .sample_hold_q (sample_hold_q),
    .trig_flags    (trig_flags),
    .vect_ack      (vect_ack),
    .pin_raw       (pin_raw),
    .pin_in_q      (pin_in_q),
    .pin_buf_off_q (pin_buf_off_q)
  );

  adcdc_core_model u_core (
    .core_clk      (core_clk),
    .sample_hold_q (sample_hold_q),
    .want_mag      (want_mag),
    .want_neg      (want_neg),
    .want_flags    (want_flags),
    .want_pins     (want_pins),
    .core_mag      (core_mag),
    .core_neg      (core_neg),
    .trig_flags    (trig_flags),
    .pin_raw       (pin_raw)
  );

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [5:0] a,
                        input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata_q}, {8'h00, exp});
  endtask

  // wait for a start, then count ticks and tick spacing until done
  task automatic run_conv();
    int n;
    int first;
    started = 1'b0;
    ticks   = 0;
    per     = 0;
    first   = 0;
    for (n = 0; n < 12 && !started; n++)
    begin
      @(posedge core_clk);
      #1;
      started = (sample_hold_q === 1'b1);
    end
    n = 0;
    while (started && sample_hold_q === 1'b1 && n < 4000)
    begin
      if (conv_clk_q === 1'b1)
      begin
        ticks++;
        if (ticks == 1) first = n;
        if (ticks == 2) per = n - first;
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    // the closing tick shows as the hold output falls
    if (started && conv_clk_q === 1'b1)
      ticks++;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n    = 1'b0;
    reg_addr   = 6'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    vect_ack   = 1'b0;
    want_mag   = 10'h000;
    want_neg   = 1'b0;
    want_flags = 7'h00;
    want_pins  = 8'h00;
    cycles     = 0;
    amap = '{adcdc_pkg::OFS_PIN_DIS, adcdc_pkg::OFS_CTRL2,
             adcdc_pkg::OFS_RES_LO, adcdc_pkg::OFS_RES_HI,
             adcdc_pkg::OFS_CTRL1, 6'h3f};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset contents and an unmapped place
    foreach (amap[i])
      rd_chk("reset value", amap[i], 8'h00);
    // second control: reserved zero, storage bit
    wr(adcdc_pkg::OFS_CTRL2, 8'hdf);
    rd_chk("ctrl2 all ones", adcdc_pkg::OFS_CTRL2, 8'hdf);
    wr(adcdc_pkg::OFS_CTRL2, 8'h08);
    rd_chk("ctrl2 spare", adcdc_pkg::OFS_CTRL2, 8'h08);
    wr(adcdc_pkg::OFS_CTRL2, 8'h00);
    // pin input disable
    want_pins <= 8'hff;
    wr(adcdc_pkg::OFS_PIN_DIS, 8'ha5);
    repeat (4) @(posedge core_clk);
    #1;
    chk("pin in", {8'h00, pin_in_q}, 16'h005a);
    chk("buf off", {8'h00, pin_buf_off_q}, 16'h00a5);
    rd_chk("pin dis", adcdc_pkg::OFS_PIN_DIS, 8'ha5);
    wr(adcdc_pkg::OFS_PIN_DIS, 8'h00);
    repeat (4) @(posedge core_clk);
    #1;
    chk("pin in open", {8'h00, pin_in_q}, 16'h00ff);
    // no converter clock while disabled
    ticks = 0;
    repeat (20)
    begin
      @(posedge core_clk);
      #1;
      if (conv_clk_q === 1'b1) ticks++;
    end
    chk("idle ticks", 16'(ticks), 16'h0000);
    // first conversion together with enable
    want_mag <= 10'h2b5;
    repeat (4) @(posedge core_clk);
    wr(adcdc_pkg::OFS_CTRL1, 8'hc0);
    run_conv();
    chk("first ticks", 16'(ticks), 16'h0019);
    chk("div 2", 16'(per), 16'h0002);
    rd_chk("flag set", adcdc_pkg::OFS_CTRL1, 8'h90);
    rd_chk("res lo", adcdc_pkg::OFS_RES_LO, 8'hb5);
    rd_chk("res hi", adcdc_pkg::OFS_RES_HI, 8'h02);
    wr(adcdc_pkg::OFS_CTRL2, 8'h10);
    rd_chk("left lo", adcdc_pkg::OFS_RES_LO, 8'h40);
    rd_chk("left hi", adcdc_pkg::OFS_RES_HI, 8'had);
    wr(adcdc_pkg::OFS_CTRL2, 8'h00);
    wr(adcdc_pkg::OFS_CTRL1, 8'h90);
    rd_chk("flag w1c", adcdc_pkg::OFS_CTRL1, 8'h80);
    // divider codes 1 to 7, normal length
    for (int c = 1; c < 8; c++)
    begin
      wr(adcdc_pkg::OFS_CTRL1, 8'hc0 | 8'(c));
      run_conv();
      chk("ticks", 16'(ticks), 16'h000d);
      chk("divider", 16'(per), 16'(1 << c));
    end
    // low byte read locks out a new result
    want_mag <= 10'h155;
    repeat (4) @(posedge core_clk);
    rd_chk("lock lo", adcdc_pkg::OFS_RES_LO, 8'hb5);
    wr(adcdc_pkg::OFS_CTRL1, 8'hc0);
    run_conv();
    rd_chk("locked hi", adcdc_pkg::OFS_RES_HI, 8'h02);
    wr(adcdc_pkg::OFS_CTRL1, 8'hc0);
    run_conv();
    rd_chk("new lo", adcdc_pkg::OFS_RES_LO, 8'h55);
    rd_chk("new hi", adcdc_pkg::OFS_RES_HI, 8'h01);
    // unipolar saturation, then bipolar
    want_neg <= 1'b1;
    want_mag <= 10'h100;
    repeat (4) @(posedge core_clk);
    wr(adcdc_pkg::OFS_CTRL1, 8'hc0);
    run_conv();
    rd_chk("sat lo", adcdc_pkg::OFS_RES_LO, 8'hff);
    rd_chk("sat hi", adcdc_pkg::OFS_RES_HI, 8'h03);
    wr(adcdc_pkg::OFS_CTRL2, 8'h80);
    rd_chk("bipolar bit", adcdc_pkg::OFS_CTRL2, 8'h80);
    wr(adcdc_pkg::OFS_CTRL1, 8'hc0);
    run_conv();
    rd_chk("bip lo", adcdc_pkg::OFS_RES_LO, 8'h80);
    rd_chk("bip hi", adcdc_pkg::OFS_RES_HI, 8'h03);
    // vector acknowledge clears the flag
    @(posedge core_clk);
    vect_ack <= 1'b1;
    @(posedge core_clk);
    vect_ack <= 1'b0;
    rd_chk("ack clear", adcdc_pkg::OFS_CTRL1, 8'h80);
    want_neg <= 1'b0;
    wr(adcdc_pkg::OFS_CTRL2, 8'h00);
    // auto trigger from each source
    wr(adcdc_pkg::OFS_CTRL1, 8'ha0);
    for (int k = 1; k < 8; k++)
    begin
      wr(adcdc_pkg::OFS_CTRL2, 8'(k));
      @(posedge core_clk);
      want_flags <= 7'(1 << (k - 1));
      run_conv();
      chk("auto start", 16'(started), 16'h0001);
      want_flags <= 7'h00;
    end
    // selection ignored with auto trigger off
    wr(adcdc_pkg::OFS_CTRL1, 8'h80);
    wr(adcdc_pkg::OFS_CTRL2, 8'h01);
    @(posedge core_clk);
    want_flags <= 7'h01;
    run_conv();
    chk("auto off", 16'(started), 16'h0000);
    // reselect from a clear flag to a set one
    want_flags <= 7'h02;
    wr(adcdc_pkg::OFS_CTRL1, 8'ha0);
    wr(adcdc_pkg::OFS_CTRL2, 8'h02);
    run_conv();
    chk("reselect", 16'(started), 16'h0001);
    // free running select with the complete flag set
    want_flags <= 7'h00;
    repeat (4) @(posedge core_clk);
    wr(adcdc_pkg::OFS_CTRL2, 8'h00);
    run_conv();
    chk("free select", 16'(started), 16'h0000);
    wr(adcdc_pkg::OFS_CTRL1, 8'h00);
    finish_test();
  end
endmodule

// ==== verif/adcdc_core_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// analog core and trigger event sources
// ------------------------------------------------------------
module adcdc_core_model (
  input  wire logic       core_clk,
  input  wire logic       sample_hold_q,
  input  wire logic [9:0] want_mag,
  input  wire logic       want_neg,
  input  wire logic [7:1] want_flags,
  input  wire logic [7:0] want_pins,
  output logic      [9:0] core_mag,
  output logic            core_neg,
  output logic      [7:1] trig_flags,
  output logic      [7:0] pin_raw
);
  // analog input only moves outside a sample window
  always @(posedge core_clk)
  begin
    if (sample_hold_q !== 1'b1)
    begin
      core_mag <= want_mag;
      core_neg <= want_neg;
    end
  end

  // event flags and pin levels follow the request
  assign trig_flags = want_flags;
  assign pin_raw    = want_pins;
endmodule
